/* core/rsp_pkg.sv */
// Constants shared by the radio serial host port and its input synchroniser.
package rsp_pkg;

    // Synchroniser lanes for inputs that arrive from outside the sys_clk domain.
    localparam int SY_SCK = 0;
    localparam int SY_SEL_N = 1;
    localparam int SY_MOSI = 2;
    localparam int SY_SHARED_SERIAL_DATA_PIN = 3;
    localparam int SY_OSC = 4;
    localparam int SY_LOWBAT = 5;
    localparam int SYNC_W = 6;
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h02;

    // Command byte layout.
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_INC_BIT = 6;
    localparam int ADDR_W = 6;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // Register addresses of the registers held inside this block.
    localparam logic [5:0] REG_TX_IRQ_EN = 6'h02;
    localparam logic [5:0] REG_TX_STATUS = 6'h04;
    localparam logic [5:0] REG_RX_IRQ_EN = 6'h05;
    localparam logic [5:0] REG_RX_CFG = 6'h06;
    localparam logic [5:0] REG_RX_STATUS = 6'h08;
    localparam logic [5:0] REG_SYS_STATUS = 6'h09;
    localparam logic [5:0] REG_IRQ_CFG = 6'h0A;
    localparam logic [5:0] REG_CLK_CFG = 6'h0B;
    localparam logic [5:0] REG_PWR_CFG = 6'h0C;
    localparam logic [5:0] REG_SYS_IRQ_EN = 6'h0D;
    localparam logic [5:0] REG_XACT_CFG = 6'h0F;
    localparam logic [5:0] REG_RSSI = 6'h13;

    // Transaction configuration fields.
    localparam int XACT_FORCE_BIT = 5;
    localparam int XACT_END_MSB = 4;
    localparam int XACT_END_LSB = 2;
    localparam logic [2:0] END_SLEEP = 3'h0;
    localparam logic [7:0] XACT_FORCE_MASK = 8'h20;

    // Interrupt pin configuration fields.
    localparam int IRQ_POL_HIGH_BIT = 0;
    localparam int IRQ_OPEN_DRAIN_BIT = 1;
    localparam int IRQ_ON_MOSI_BIT = 2;
    localparam int THREE_WIRE_BIT = 3;

    // Clock output: enable and rate select (0:12, 1:6, 2:3, 3:1.5, 4:0.75 MHz).
    localparam int CLK_EN_BIT = 3;
    localparam int CLK_SEL_MSB = 2;
    localparam logic [7:0] CLK_CFG_RST = 8'h08;

    // Power configuration: automatic sleep and low-battery threshold index.
    localparam int PWR_AUTO_SLEEP_BIT = 3;
    localparam int PWR_LB_MSB = 2;

    // Receiver configuration.
    localparam int RX_AGC_BIT = 7;
    localparam int RX_GAIN_BIT = 6;
    localparam int RX_ATT_BIT = 5;
    localparam logic [7:0] RX_CFG_RST = 8'h40;

    // System status bits.
    localparam int SYS_OSC_RDY_BIT = 0;
    localparam int SYS_LOWBAT_BIT = 1;

    // Least spacing between two signal-strength samples.
    localparam int CLK_PERIOD_NS = 5;
    localparam int RSSI_GAP_NS = 12000;
    localparam int RSSI_GAP_CYC = (RSSI_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RSSI_TMR_W = 12;
    localparam logic [RSSI_TMR_W-1:0] RSSI_TMR_LOAD = RSSI_TMR_W'(RSSI_GAP_CYC - 1);

endpackage

/* core/rsp_sync.sv */
// Three-stage input synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rsp_sync (
    input wire logic sys_clk, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [rsp_pkg::SYNC_W-1:0] async_in, // Raw pin levels.
    output logic [rsp_pkg::SYNC_W-1:0] sync_out // Filtered, synchronous levels.
);
    import rsp_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] out;
    } rsp_sync_t;

    rsp_sync_t q_q;
    rsp_sync_t q_d;

    always_comb begin
        q_d = q_q;
        q_d.s1 = async_in;
        q_d.s2 = q_q.s1;
        q_d.s3 = q_q.s2;
        // Only lanes where the two settled stages agree are allowed to move.
        q_d.out = (q_q.s2 ~^ q_q.s3) & q_q.s3 | (q_q.s2 ^ q_q.s3) & q_q.out;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_q.s1 <= SYNC_RST;
            q_q.s2 <= SYNC_RST;
            q_q.s3 <= SYNC_RST;
            q_q.out <= SYNC_RST;
        end else begin
            q_q <= q_d;
        end
    end

    assign sync_out = q_q.out;

endmodule // rsp_sync
`default_nettype wire

/* core/rsp_port.sv */
// Serial register port of the radio with interrupt pin, sleep control and signal strength.
//
// Overview of operation
// - Command byte bit 7 high means register write, low means register read.
// - Command bit 6 set advances the address after every data byte.
// - Command byte carries a six-bit address; eight-bit data bytes follow.
// - Host clocks and selects low; data in on master-out, out on master-in.
// - Any number of data bytes follow; select high ends the burst.
// - FIFO files use non-incrementing bursts so bytes hit one address.
// - Three-wire mode shares one data pin; host tri-states except sending.
// - Interrupt on master-out pin only while select high; host releases it.
// - Serial port works without the internal oscillator, so in sleep too.
// - Interrupt polarity and push-pull or open-drain driver are programmable.
// - Transmit, receive and system sources share one pin, each enabled.
// - Interrupt enables survive switching between transmit and receive.
// - Status bits show events even when their enable is off.
// - Clock output with five selectable rates, on after reset, can stop.
// - Force-finish with end state zero puts device to sleep promptly.
// - Optional sleep after transaction; wake when told to transmit or receive.
// - After wake, optional interrupt once the oscillator is stable.
// - Low-battery result readable, live not latched, unmonitored in sleep.
// - Without auto gain the gain bit sets gain; attenuation bit adds loss.
// - During receive, five-bit strength sample taken at start of packet.
// - Each strength read triggers a new sample, at most one per 12 us.
`timescale 1ns/1ps
`default_nettype none
module rsp_port (
    input wire logic sys_clk, // Always-on system clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic spi_sck, // Serial clock pin from the host.
    input wire logic spi_sel_n, // Select pin from the host, active low.
    input wire logic spi_mosi_i, // Master-out pin level.
    output logic spi_mosi_o, // Master-out pin drive value (interrupt option).
    output logic spi_mosi_oe, // Master-out pin drive enable.
    output logic spi_miso_o, // Master-in pin drive value.
    output logic spi_miso_oe, // Master-in pin drive enable.
    input wire logic shared_serial_data_pin_i, // Shared serial data pin level.
    output logic shared_serial_data_pin_o, // Shared serial data pin drive value.
    output logic shared_serial_data_pin_oe, // Shared serial data pin drive enable.
    output logic irq_o, // Interrupt pin drive value.
    output logic irq_oe, // Interrupt pin drive enable.
    output logic [rsp_pkg::ADDR_W-1:0] ext_raddr, // Read address for outside registers.
    input wire logic [7:0] ext_rdata, // Outside register data for ext_raddr.
    output logic ext_rd_stb, // Outside register was read (FIFO pop).
    output logic ext_wr_stb, // Outside register write strobe.
    output logic [rsp_pkg::ADDR_W-1:0] ext_addr, // Address of the strobed access.
    output logic [7:0] ext_wdata, // Data of the write strobe.
    input wire logic [7:0] tx_status, // Transmit event conditions.
    input wire logic [7:0] rx_status, // Receive event conditions.
    input wire logic radio_go, // Pulse: radio commanded into transmit or receive.
    input wire logic xact_done, // Pulse: packet transaction finished.
    input wire logic osc_stable, // Oscillator stable indication (asynchronous).
    output logic osc_enable, // Crystal oscillator run enable.
    output logic sleep, // Device is in sleep.
    output logic [2:0] xact_end_state, // Configured transaction end state.
    input wire logic lowbat_cmp, // Battery below threshold (asynchronous).
    output logic [2:0] lowbat_thresh, // Low-battery threshold index.
    output logic lowbat_mon_en, // Battery monitor enable.
    output logic auto_gain_enable_bit, // Automatic gain control on.
    output logic receive_gain_bit, // Full receiver gain when set.
    output logic receive_attenuation_bit, // Extra receiver attenuation.
    input wire logic rx_active, // Receiver is running.
    input wire logic sop_det, // Pulse: start of packet detected.
    input wire logic [4:0] rssi_in, // Live signal-strength measurement.
    output logic clkout_en, // Clock output enable.
    output logic [2:0] clkout_sel // Clock output rate select.
);
    import rsp_pkg::*;

    typedef struct packed {
        logic sck_prev;
        logic [2:0] bit_cnt;
        logic first;
        logic dir;
        logic inc;
        logic [5:0] addr;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic [7:0] xact_cfg;
        logic [7:0] irq_cfg;
        logic [7:0] tx_en;
        logic [7:0] rx_en;
        logic [7:0] sys_en;
        logic [7:0] clk_cfg;
        logic [7:0] pwr_cfg;
        logic [7:0] rx_cfg;
        logic sleep;
        logic osc_wait;
        logic osc_rdy;
        logic [4:0] rssi;
        logic rssi_pend;
        logic [RSSI_TMR_W-1:0] rssi_tmr;
        logic ext_wr;
        logic ext_rd;
        logic [5:0] ext_addr;
        logic [7:0] ext_wdata;
    } rsp_port_t;

    rsp_port_t s_q;
    rsp_port_t s_d;

    logic [SYNC_W-1:0] pin_s;
    logic sel_n_s;
    logic sck_rise;
    logic sck_fall;
    logic three_wire;
    logic din;
    logic [7:0] byte_in;
    logic byte_done;
    logic [5:0] next_addr;
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_int;
    logic lowbat_live;
    logic [7:0] sys_stat;
    logic irq_act;
    logic irq_lvl;
    logic irq_od;

    // The port is sampled on sys_clk, which keeps running in sleep; only the crystal
    // behind osc_enable stops, so register access never depends on it.
    rsp_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({lowbat_cmp, osc_stable, shared_serial_data_pin_i, spi_mosi_i, spi_sel_n, spi_sck}),
        .sync_out(pin_s)
    );

    assign sel_n_s = pin_s[SY_SEL_N];
    assign sck_rise = pin_s[SY_SCK] & ~s_q.sck_prev & ~sel_n_s;
    assign sck_fall = ~pin_s[SY_SCK] & s_q.sck_prev & ~sel_n_s;
    assign three_wire = s_q.irq_cfg[THREE_WIRE_BIT];
    assign din = three_wire ? pin_s[SY_SHARED_SERIAL_DATA_PIN] : pin_s[SY_MOSI];
    assign byte_in = {s_q.rx_sh[6:0], din};
    assign byte_done = sck_rise & (s_q.bit_cnt == BIT_LAST);
    assign next_addr = s_q.addr + {5'h00, s_q.inc};
    assign rd_addr = s_q.first ? byte_in[5:0] : next_addr;
    assign lowbat_live = pin_s[SY_LOWBAT] & ~s_q.sleep;
    assign sys_stat = {6'h00, lowbat_live, s_q.osc_rdy};

    // Status is visible regardless of enables; the enables only gate the pin.
    assign irq_act = |(tx_status & s_q.tx_en) | |(rx_status & s_q.rx_en)
        | |(sys_stat & s_q.sys_en);
    assign irq_lvl = s_q.irq_cfg[IRQ_POL_HIGH_BIT] ? irq_act : ~irq_act;
    assign irq_od = s_q.irq_cfg[IRQ_OPEN_DRAIN_BIT];

    always_comb begin
        rd_int = 1'b1;
        unique case (rd_addr)
            REG_TX_IRQ_EN: rd_data = s_q.tx_en;
            REG_TX_STATUS: rd_data = tx_status;
            REG_RX_IRQ_EN: rd_data = s_q.rx_en;
            REG_RX_CFG: rd_data = s_q.rx_cfg;
            REG_RX_STATUS: rd_data = rx_status;
            REG_SYS_STATUS: rd_data = sys_stat;
            REG_IRQ_CFG: rd_data = s_q.irq_cfg;
            REG_CLK_CFG: rd_data = s_q.clk_cfg;
            REG_PWR_CFG: rd_data = s_q.pwr_cfg;
            REG_SYS_IRQ_EN: rd_data = s_q.sys_en;
            REG_XACT_CFG: rd_data = s_q.xact_cfg;
            REG_RSSI: rd_data = {3'h0, s_q.rssi};
            default: begin
                rd_int = 1'b0;
                rd_data = ext_rdata;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.ext_wr = 1'b0;
        s_d.ext_rd = 1'b0;
        s_d.sck_prev = pin_s[SY_SCK];
        if (s_q.rssi_tmr != '0) begin
            s_d.rssi_tmr = s_q.rssi_tmr - 1'b1;
        end
        // Wake on a transmit or receive command, sleep after a transaction if asked.
        if (radio_go && s_q.sleep) begin
            s_d.sleep = 1'b0;
            s_d.osc_wait = 1'b1;
        end else if (xact_done && s_q.pwr_cfg[PWR_AUTO_SLEEP_BIT]) begin
            s_d.sleep = 1'b1;
        end
        if (sel_n_s) begin
            s_d.bit_cnt = BIT_FIRST;
            s_d.first = 1'b1;
            s_d.tx_sh = 8'h00;
        end else if (sck_rise) begin
            s_d.rx_sh = byte_in;
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
        end else if (sck_fall && s_q.bit_cnt != BIT_FIRST) begin
            s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
        end
        if (byte_done) begin
            if (s_q.first) begin
                s_d.first = 1'b0;
                s_d.dir = byte_in[CMD_DIR_BIT];
                s_d.inc = byte_in[CMD_INC_BIT];
                s_d.addr = byte_in[5:0];
            end else begin
                s_d.addr = next_addr;
            end
            if (s_q.first ? !byte_in[CMD_DIR_BIT] : !s_q.dir) begin
                // Read: prefetch the byte for the next eight clocks.
                s_d.tx_sh = rd_data;
                s_d.ext_rd = ~rd_int;
                s_d.ext_addr = rd_addr;
                if (rd_addr == REG_SYS_STATUS) begin
                    s_d.osc_rdy = 1'b0;
                end
                if (rd_addr == REG_RSSI) begin
                    s_d.rssi_pend = 1'b1;
                end
            end else if (!s_q.first) begin
                unique case (s_q.addr)
                    REG_TX_IRQ_EN: s_d.tx_en = byte_in;
                    REG_RX_IRQ_EN: s_d.rx_en = byte_in;
                    REG_SYS_IRQ_EN: s_d.sys_en = byte_in;
                    REG_RX_CFG: s_d.rx_cfg = byte_in;
                    REG_IRQ_CFG: s_d.irq_cfg = byte_in;
                    REG_CLK_CFG: s_d.clk_cfg = byte_in;
                    REG_PWR_CFG: s_d.pwr_cfg = byte_in;
                    REG_XACT_CFG: begin
                        // The force bit acts once and is not stored.
                        s_d.xact_cfg = byte_in & ~XACT_FORCE_MASK;
                        if (byte_in[XACT_FORCE_BIT]
                            && byte_in[XACT_END_MSB:XACT_END_LSB] == END_SLEEP) begin
                            s_d.sleep = 1'b1;
                            s_d.osc_wait = 1'b0;
                        end
                    end
                    REG_TX_STATUS, REG_RX_STATUS, REG_SYS_STATUS, REG_RSSI: begin
                        s_d.ext_wr = 1'b0;
                    end
                    default: begin
                        s_d.ext_wr = 1'b1;
                        s_d.ext_addr = s_q.addr;
                        s_d.ext_wdata = byte_in;
                    end
                endcase
            end
        end
        // A stable oscillator after wake sets the flag even in a clearing read.
        if (s_q.osc_wait && pin_s[SY_OSC] && !s_d.sleep) begin
            s_d.osc_wait = 1'b0;
            s_d.osc_rdy = 1'b1;
        end
        if (sop_det && rx_active) begin
            s_d.rssi_pend = 1'b1;
        end
        // One timer spaces every sample, whether caused by a packet or a read.
        if (s_q.rssi_pend && rx_active && s_q.rssi_tmr == '0) begin
            s_d.rssi = rssi_in;
            s_d.rssi_pend = 1'b0;
            s_d.rssi_tmr = RSSI_TMR_LOAD;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.first <= 1'b1;
            s_q.clk_cfg <= CLK_CFG_RST;
            s_q.rx_cfg <= RX_CFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Pins. In three-wire mode only the read data phase drives the shared pin.
    assign spi_miso_o = s_q.tx_sh[7];
    assign spi_miso_oe = ~sel_n_s & ~three_wire;
    assign shared_serial_data_pin_o = s_q.tx_sh[7];
    assign shared_serial_data_pin_oe = ~sel_n_s & three_wire & ~s_q.first & ~s_q.dir;
    assign spi_mosi_o = irq_od ? 1'b0 : irq_lvl;
    assign spi_mosi_oe = s_q.irq_cfg[IRQ_ON_MOSI_BIT] & sel_n_s & (~irq_od | ~irq_lvl);
    assign irq_o = irq_od ? 1'b0 : irq_lvl;
    assign irq_oe = ~irq_od | ~irq_lvl;
    assign ext_raddr = rd_addr;
    assign ext_rd_stb = s_q.ext_rd;
    assign ext_wr_stb = s_q.ext_wr;
    assign ext_addr = s_q.ext_addr;
    assign ext_wdata = s_q.ext_wdata;
    assign sleep = s_q.sleep;
    assign osc_enable = ~s_q.sleep;
    assign xact_end_state = s_q.xact_cfg[XACT_END_MSB:XACT_END_LSB];
    assign lowbat_thresh = s_q.pwr_cfg[PWR_LB_MSB:0];
    assign lowbat_mon_en = ~s_q.sleep;
    assign auto_gain_enable_bit = s_q.rx_cfg[RX_AGC_BIT];
    assign receive_gain_bit = s_q.rx_cfg[RX_GAIN_BIT];
    assign receive_attenuation_bit = s_q.rx_cfg[RX_ATT_BIT];
    assign clkout_en = s_q.clk_cfg[CLK_EN_BIT];
    assign clkout_sel = s_q.clk_cfg[CLK_SEL_MSB:0];

    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_cmd_byte;
        byte_done && s_q.first;
    endsequence

    sequence s_data_byte;
        byte_done && !s_q.first;
    endsequence

    sequence s_force_write;
        s_data_byte ##0 s_q.dir && s_q.addr == REG_XACT_CFG && byte_in[XACT_FORCE_BIT]
            && byte_in[XACT_END_MSB:XACT_END_LSB] == END_SLEEP;
    endsequence

    property p_cmd_dir;
        s_cmd_byte |=> s_q.dir == $past(byte_in[CMD_DIR_BIT]) && !s_q.first;
    endproperty
    a_cmd_dir: assert property (p_cmd_dir) else $error("command direction not captured");

    property p_addr_inc;
        s_data_byte ##0 s_q.inc |=> s_q.addr == $past(s_q.addr) + 6'h01;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");

    property p_addr_hold;
        s_data_byte ##0 !s_q.inc ##1 !byte_done [*2] |-> s_q.addr == $past(s_q.addr, 2);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in fixed burst");

    property p_sel_end;
        sel_n_s |=> s_q.first && s_q.bit_cnt == BIT_FIRST;
    endproperty
    a_sel_end: assert property (p_sel_end) else $error("select high did not end burst");

    property p_force_sleep;
        s_force_write ##0 !radio_go |=> s_q.sleep && !osc_enable;
    endproperty
    a_force_sleep: assert property (p_force_sleep) else $error("forced sleep not entered");

    property p_wake;
        radio_go && s_q.sleep && !byte_done |=> !sleep ##0 osc_enable;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on radio command");

    property p_irq_drive;
        !irq_od |-> irq_oe && irq_o == (s_q.irq_cfg[IRQ_POL_HIGH_BIT] ~^ irq_act);
    endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("interrupt pin level wrong");

    property p_mosi_free;
        !sel_n_s |-> !spi_mosi_oe;
    endproperty
    a_mosi_free: assert property (p_mosi_free) else $error("master-out driven while selected");

    property p_lowbat_live;
        sys_stat[SYS_LOWBAT_BIT] == (pin_s[SY_LOWBAT] && !sleep);
    endproperty
    a_lowbat_live: assert property (p_lowbat_live) else $error("low battery status wrong");

    property p_rssi_gap;
        s_q.rssi_tmr == RSSI_TMR_LOAD |-> $past(s_q.rssi_tmr) == '0 && $past(s_q.rssi_pend);
    endproperty
    a_rssi_gap: assert property (p_rssi_gap) else $error("strength sample too soon");

endmodule // rsp_port
`default_nettype wire

/* verification/rsp_host_model.sv */
// Host bus master model that clocks command and data bytes through the radio serial port.
`timescale 1ns/1ps
`default_nettype none
module rsp_host_model (
    input wire logic sys_clk, // Bench clock used to time each serial phase.
    output logic sck, // Serial clock, idles low.
    output logic sel_n, // Select, active low.
    output logic mosi, // Master-out data.
    input wire logic miso // Master-in data.
);
    task automatic gap(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start();
        sel_n = 1'b0;
        gap(8);
    endtask
    // A released data line toggles, so a stale level is never taken for an answer.
    task automatic stop();
        gap(8);
        sel_n = 1'b1;
        mosi = ~mosi;
        gap(8);
    endtask
    // Eight cycles a phase keeps well inside the port's pin sampling margin.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            gap(8);
            sck = 1'b1;
            rx[i] = miso;
            gap(8);
            sck = 1'b0;
        end
    endtask
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
endmodule // rsp_host_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the radio serial port: registers, interrupt pin, sleep and strength.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, reset_n, sck, sel_n, mosi, miso, spi_miso_o, spi_miso_oe, irq_o, irq_oe;
    logic radio_go, xact_done, osc_stable, lowbat_cmp, rx_active, sop_det, clkout_en;
    logic ext_rd_stb, ext_wr_stb, osc_enable, sleep, lowbat_mon_en;
    logic auto_gain_enable_bit, receive_gain_bit, receive_attenuation_bit;
    logic [7:0] tx_status, rx_status, ext_rdata, ext_wdata;
    logic [7:0] rb [3];
    logic [5:0] ext_raddr, ext_addr;
    logic [4:0] rssi_in;
    logic [2:0] clkout_sel, lowbat_thresh;
    int bad_count = 0;
    int samples_checked = 0;
    int stb_n = 0;
    int wr_n = 0;
    assign ext_rdata = {2'h2, ext_raddr};
    assign miso = spi_miso_oe ? spi_miso_o : ~spi_miso_o;
    rsp_port uut (.sys_clk, .reset_n, .spi_sck(sck), .spi_sel_n(sel_n), .spi_mosi_i(mosi),
        .spi_mosi_o(), .spi_mosi_oe(), .spi_miso_o, .spi_miso_oe, .shared_serial_data_pin_i(mosi), .shared_serial_data_pin_o(),
        .shared_serial_data_pin_oe(), .irq_o, .irq_oe, .ext_raddr, .ext_rdata, .ext_rd_stb, .ext_wr_stb,
        .ext_addr, .ext_wdata, .tx_status, .rx_status, .radio_go, .xact_done, .osc_stable,
        .osc_enable, .sleep, .xact_end_state(), .lowbat_cmp, .lowbat_thresh, .lowbat_mon_en,
        .auto_gain_enable_bit, .receive_gain_bit, .receive_attenuation_bit, .rx_active,
        .sop_det, .rssi_in, .clkout_en, .clkout_sel);
    rsp_host_model host (.sys_clk, .sck, .sel_n, .mosi, .miso);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (ext_rd_stb === 1'b1) stb_n++;
        if (ext_wr_stb === 1'b1) wr_n++;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [7:0] cmd, input int n, input logic [7:0] d0, d1);
        host.start();
        host.xfer(cmd, rb[2]);
        host.xfer(d0, rb[0]);
        if (n > 1) host.xfer(d1, rb[1]);
        host.stop();
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {reset_n, radio_go, xact_done, osc_stable, lowbat_cmp, rx_active, sop_det} = 7'h00;
        {tx_status, rx_status, rssi_in} = 21'h0_0000;
        repeat (20) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        host.gap(4);
        check({2'h0, clkout_en, receive_gain_bit, sleep, irq_o, irq_oe, osc_enable}, 8'h37);
        check({5'h00, clkout_sel}, 8'h00);
        op(8'h8B, 1, 8'h05, 8'h00);
        check({4'h0, clkout_en, clkout_sel}, 8'h05);
        op(8'hC5, 2, 8'hFF, 8'h20);
        check({5'h00, auto_gain_enable_bit, receive_gain_bit, receive_attenuation_bit}, 8'h01);
        rx_status = 8'h10;
        host.gap(2);
        check({6'h00, irq_o, irq_oe}, 8'h01);
        // Active high and open drain: an asserted pin is released, an idle one pulled low.
        op(8'h8A, 1, 8'h03, 8'h00);
        check({6'h00, irq_o, irq_oe}, 8'h00);
        rx_status = 8'h00;
        host.gap(2);
        check({6'h00, irq_o, irq_oe}, 8'h01);
        op(8'h85, 1, 8'h00, 8'h00);
        rx_status = 8'h5A;
        op(8'h08, 1, 8'h00, 8'h00);
        check(rb[0], 8'h5A);
        check({6'h00, irq_o, irq_oe}, 8'h01);
        stb_n = 0;
        op(8'h20, 2, 8'h00, 8'h00);
        check(rb[0], 8'hA0);
        check(rb[1], 8'hA0);
        check(8'(stb_n), 8'h03);
        op(8'h60, 2, 8'h00, 8'h00);
        check(rb[1], 8'hA1);
        op(8'hA1, 1, 8'h3C, 8'h00);
        check({2'h0, ext_addr}, 8'h21);
        check(ext_wdata, 8'h3C);
        check(8'(wr_n), 8'h01);
        op(8'h8F, 1, 8'h20, 8'h00);
        check({5'h00, sleep, osc_enable, lowbat_mon_en}, 8'h04);
        op(8'h0B, 1, 8'h00, 8'h00);
        check(rb[0], 8'h05);
        radio_go = 1'b1;
        host.gap(1);
        radio_go = 1'b0;
        host.gap(4);
        check({5'h00, sleep, osc_enable, lowbat_mon_en}, 8'h03);
        osc_stable = 1'b1;
        op(8'h09, 1, 8'h00, 8'h00);
        check(rb[0], 8'h01);
        lowbat_cmp = 1'b1;
        op(8'h8C, 1, 8'h0E, 8'h00);
        check({5'h00, lowbat_thresh}, 8'h06);
        op(8'h09, 1, 8'h00, 8'h00);
        check(rb[0], 8'h02);
        xact_done = 1'b1;
        host.gap(1);
        xact_done = 1'b0;
        host.gap(1);
        check({5'h00, sleep, osc_enable, lowbat_mon_en}, 8'h04);
        // In sleep the battery monitor is off, so the live bit must read low.
        op(8'h09, 1, 8'h00, 8'h00);
        check(rb[0], 8'h00);
        rx_active = 1'b1;
        rssi_in = 5'h11;
        sop_det = 1'b1;
        host.gap(1);
        sop_det = 1'b0;
        op(8'h13, 1, 8'h00, 8'h00);
        check(rb[0], 8'h11);
        rssi_in = 5'h07;
        op(8'h13, 1, 8'h00, 8'h00);
        check(rb[0], 8'h11);
        op(8'h13, 1, 8'h00, 8'h00);
        check(rb[0], 8'h11);
        host.gap(2400);
        op(8'h13, 1, 8'h00, 8'h00);
        check(rb[0], 8'h07);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
